// >>> bench/pin_partner.sv
// Behavioural source of pulses on the capture pins
module pin_partner (
  input  wire logic       clk_in,
  input  wire logic [7:0] pulse_req_in,
  output logic [7:0]      pins_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] held = 8'h00;
  logic [1:0] left = 2'h0;
  // Two clocks high, so a slow edge detector still sees each pulse
  always @(posedge clk_in) begin
    if (pulse_req_in != 8'h00) begin
      held <= pulse_req_in;
      left <= 2'h2;
    end else if (left != 2'h0) begin
      left <= left - 2'h1;
    end
  end
  assign pins_out = (left != 2'h0) ? held : 8'h00;
endmodule // pin_partner

// >>> bench/timer_capture_match_unit_tb_top.sv
// Self-checking bench for the timer capture match unit
module timer_capture_match_unit_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic           clk_in      = 1'b0;
  logic           rst_n_in    = 1'b0;
  tmr_pkg::addr_t awaddr_in   = 8'h00;
  tmr_pkg::addr_t araddr_in   = 8'h00;
  tmr_pkg::word_t wdata_in    = 32'h0;
  logic [3:0]     wstrb_in    = 4'h0;
  logic           awvalid_in  = 1'b0;
  logic           wvalid_in   = 1'b0;
  logic           bready_in   = 1'b0;
  logic           arvalid_in  = 1'b0;
  logic           rready_in   = 1'b0;
  logic [7:0]     pulse_req   = 8'h00;
  logic           awready_out, wready_out, bvalid_out, arready_out;
  logic           rvalid_out, irq_out;
  logic [1:0]     bresp_out, rresp_out, bres, rres;
  logic [7:0]     cap_pins_in, match_pins_out;
  tmr_pkg::word_t rdata_out, rdat;
  int             err_total   = 0;
  int             check_count = 0;
  int             cycles      = 0;

  timer_capture_match_unit timer_capture_match_unit_i (
    .clk_in, .rst_n_in, .awaddr_in, .awvalid_in, .awready_out, .wdata_in,
    .wstrb_in, .wvalid_in, .wready_out, .bresp_out, .bvalid_out, .bready_in,
    .araddr_in, .arvalid_in, .arready_out, .rdata_out, .rresp_out,
    .rvalid_out, .rready_in, .cap_pins_in,
    .match_pins_out, .irq_out
  );
  pin_partner pin_partner_i (
    .clk_in, .pulse_req_in(pulse_req), .pins_out(cap_pins_in)
  );

  always #2 clk_in = ~clk_in;

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Generous ceiling: the whole sequence needs a few hundred cycles
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total++;
      finish_test();
    end
  end

  task automatic check(input tmr_pkg::word_t seen,
                       input tmr_pkg::word_t exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input tmr_pkg::addr_t a, input tmr_pkg::word_t d);
    logic aw_done = 1'b0;
    logic w_done  = 1'b0;
    @(posedge clk_in);
    awaddr_in  <= a;
    wdata_in   <= d;
    wstrb_in   <= 4'hf;
    awvalid_in <= 1'b1;
    wvalid_in  <= 1'b1;
    bready_in  <= 1'b1;
    // Each write channel is released only when its own ready is seen
    do begin
      @(posedge clk_in);
      aw_done = aw_done || (awready_out === 1'b1);
      w_done  = w_done || (wready_out === 1'b1);
      if (aw_done) awvalid_in <= 1'b0;
      if (w_done) wvalid_in <= 1'b0;
    end while (!(aw_done && w_done));
    do @(posedge clk_in); while (bvalid_out !== 1'b1);
    bres = bresp_out;
    bready_in <= 1'b0;
  endtask

  task automatic rd(input tmr_pkg::addr_t a);
    @(posedge clk_in);
    araddr_in  <= a;
    arvalid_in <= 1'b1;
    rready_in  <= 1'b1;
    do @(posedge clk_in); while (arready_out !== 1'b1);
    arvalid_in <= 1'b0;
    do @(posedge clk_in); while (rvalid_out !== 1'b1);
    rdat = rdata_out;
    rres = rresp_out;
    rready_in <= 1'b0;
  endtask

  task automatic rdchk(input tmr_pkg::addr_t a, input tmr_pkg::word_t e);
    rd(a);
    check(rdat, e);
  endtask

  task automatic pulse(input logic [7:0] m);
    @(posedge clk_in);
    pulse_req <= m;
    @(posedge clk_in);
    pulse_req <= 8'h00;
    repeat (5) @(posedge clk_in);
  endtask

  task automatic t_regs();
    rdchk(tmr_pkg::OFS_CTRL, 32'h0);
    rdchk(tmr_pkg::OFS_PRESCALE, 32'h0);
    wr(tmr_pkg::OFS_PRESCALE, 32'hffff_ffff);
    rdchk(tmr_pkg::OFS_PRESCALE, 32'hffff_ffff);
    wr(tmr_pkg::OFS_PRESCALE, 32'h0);
    wr(tmr_pkg::OFS_CAPTURE0, 32'h1234_5678);
    check(tmr_pkg::word_t'(bres), tmr_pkg::word_t'(tmr_pkg::RESP_OKAY));
    rdchk(tmr_pkg::OFS_CAPTURE0, 32'h0);
    wr(8'h50, 32'h1);
    check(tmr_pkg::word_t'(bres), tmr_pkg::word_t'(tmr_pkg::RESP_SLVERR));
    rdchk(8'h02, 32'h0);
    check(tmr_pkg::word_t'(rres), tmr_pkg::word_t'(tmr_pkg::RESP_SLVERR));
    $display("test regs done");
  endtask

  // Stop on match with every output action in turn
  task automatic t_stop();
    logic [3:0]     init_v = 4'b1011;
    logic [3:0]     exp_v  = 4'b0101;
    tmr_pkg::word_t ext;
    wr(tmr_pkg::OFS_MATCH0, 32'h3);
    wr(tmr_pkg::OFS_MATCH_CTL, 32'h5);
    wr(tmr_pkg::OFS_IRQ_MASK, 32'h1);
    for (int i = 0; i < 4; i++) begin
      ext = (tmr_pkg::word_t'(i) << 4) | tmr_pkg::word_t'(init_v[i]);
      wr(tmr_pkg::OFS_CTRL, 32'h2);
      wr(tmr_pkg::OFS_EXT_MATCH, ext);
      wr(tmr_pkg::OFS_CTRL, 32'h1);
      repeat (12) @(posedge clk_in);
      check(tmr_pkg::word_t'(irq_out), 32'h1);
      check(tmr_pkg::word_t'(match_pins_out), {24'h0, {8{exp_v[i]}}});
      rdchk(tmr_pkg::OFS_CTRL, 32'h0);
      rdchk(tmr_pkg::OFS_IRQ_STAT, 32'h1);
      rdchk(tmr_pkg::OFS_EXT_MATCH, {ext[31:1], exp_v[i]});
    end
    wr(tmr_pkg::OFS_IRQ_MASK, 32'h0);
    $display("test stop done");
  endtask

  // Reset on match of channel 1, toggling pin 0, prescale of 1
  task automatic t_toggle();
    logic p;
    int   n = 0;
    int   k = 0;
    wr(tmr_pkg::OFS_CTRL, 32'h2);
    wr(tmr_pkg::OFS_PRESCALE, 32'h1);
    wr(tmr_pkg::OFS_MATCH0 + tmr_pkg::WORD_STEP, 32'h2);
    wr(tmr_pkg::OFS_MATCH_CTL, 32'h10);
    wr(tmr_pkg::OFS_EXT_MATCH, 32'hc0);
    wr(tmr_pkg::OFS_PIN_ROUTE, 32'h1);
    wr(tmr_pkg::OFS_CTRL, 32'h1);
    p = match_pins_out[0];
    for (int t = 0; t < 200 && k < 4; t++) begin
      @(posedge clk_in);
      n++;
      if (match_pins_out[0] !== p) begin
        p = match_pins_out[0];
        if (k > 0) check(tmr_pkg::word_t'(n), 32'h6);
        k++;
        n = 0;
      end
    end
    check(tmr_pkg::word_t'(k), 32'h4);
    wr(tmr_pkg::OFS_CTRL, 32'h0);
    wr(tmr_pkg::OFS_PRESCALE, 32'h0);
    wr(tmr_pkg::OFS_MATCH_CTL, 32'h0);
    $display("test toggle done");
  endtask

  // Counter held still so the captured value is known exactly
  task automatic t_capture();
    wr(tmr_pkg::OFS_COUNT, 32'habc);
    wr(tmr_pkg::OFS_CAP_ROUTE, 32'h0404_0000);
    wr(tmr_pkg::OFS_CAP_CTL, 32'h340);
    pulse(8'h04);
    check(tmr_pkg::word_t'(irq_out), 32'h0);
    rdchk(tmr_pkg::OFS_CAPTURE0 + 8'h08, 32'habc);
    rdchk(tmr_pkg::OFS_CAPTURE0 + 8'h0c, 32'habc);
    wr(tmr_pkg::OFS_IRQ_MASK, 32'hc0);
    repeat (3) @(posedge clk_in);
    check(tmr_pkg::word_t'(irq_out), 32'h1);
    rdchk(tmr_pkg::OFS_IRQ_STAT, 32'h40);
    repeat (3) @(posedge clk_in);
    check(tmr_pkg::word_t'(irq_out), 32'h0);
    rdchk(tmr_pkg::OFS_IRQ_STAT, 32'h0);
    wr(tmr_pkg::OFS_IRQ_MASK, 32'h0);
    $display("test capture done");
  endtask

  // Pin 0 clocks the count in each edge mode; channel 1 ANDs pins 1 and 3
  task automatic t_counter();
    tmr_pkg::word_t e = 32'h0;
    wr(tmr_pkg::OFS_COUNT, 32'h0);
    wr(tmr_pkg::OFS_CAP_ROUTE, 32'h0a01);
    wr(tmr_pkg::OFS_COMBINE, 32'h2);
    wr(tmr_pkg::OFS_CAP_CTL, 32'h8);
    for (int m = 1; m < 4; m++) begin
      wr(tmr_pkg::OFS_CTRL, (tmr_pkg::word_t'(m) << 2) | 32'h1);
      repeat (3) pulse(8'h01);
      e = e + ((m == 3) ? 32'h6 : 32'h3);
      rdchk(tmr_pkg::OFS_COUNT, e);
    end
    pulse(8'h02);
    rdchk(tmr_pkg::OFS_CAPTURE0 + 8'h04, 32'h0);
    pulse(8'h0a);
    rdchk(tmr_pkg::OFS_CAPTURE0 + 8'h04, 32'hc);
    wr(tmr_pkg::OFS_CTRL, 32'h0);
    $display("test counter done");
  endtask

  initial begin
    repeat (12) @(posedge clk_in);
    rst_n_in <= 1'b1;
    // Internal reset copy needs two more edges
    repeat (4) @(posedge clk_in);
    t_regs();
    t_stop();
    t_toggle();
    t_capture();
    t_counter();
    finish_test();
  end
endmodule // timer_capture_match_unit_tb_top

// >>> core/cap_input.sv
// Capture pin combiner and edge detector for one capture channel
module cap_input #(
  parameter int PINS = 8
) (
  input  wire logic            clk_in,
  input  wire logic            rst_n_in,
  input  wire logic [PINS-1:0] pins_in,
  input  wire logic [PINS-1:0] route_in,
  input  wire logic            and_mode_in,
  output logic                 rise_out,
  output logic                 fall_out
);
  logic level;
  logic prev;

  always_comb begin
    if (and_mode_in) begin
      level = (|route_in) && (&(pins_in | ~route_in)); // RL11
    end else begin
      level = |(pins_in & route_in); // RL11
    end
  end

  // One-cycle pulses are seen because each level is sampled every edge
  always_ff @(posedge clk_in or negedge rst_n_in) begin // RL9
    if (!rst_n_in) begin
      prev <= 1'b0;
    end else begin
      prev <= level;
    end
  end

  assign rise_out = level && !prev;
  assign fall_out = !level && prev;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  a_and_combine: assert property ( // RL11
    and_mode_in && ((pins_in & route_in) != route_in) |-> !rise_out)
    else $error("and-combined capture fired with a routed pin low");
  a_edge_single: assert property (rise_out |=> !rise_out)
    else $error("capture rise edge lasted two cycles");
endmodule // cap_input

// >>> core/timer_capture_match_unit.sv
// Timer/counter with prescaler, capture, match and AXI4-Lite registers
// What this block does
// [RL1] Timer mode counts clock cycles; counter mode counts edges of one input
// [RL2] 32-bit count behind a 32-bit software prescaler
// [RL3] Four capture channels load the count on input transitions
// [RL4] Capture raises interrupt only when its enable is set
// [RL5] Four 32-bit match values; match may let counting continue, optional irq
// [RL6] Match can halt the counter, optional interrupt
// [RL7] Match can reset the counter to zero and keep counting
// [RL8] Four match outputs: set low, set high, toggle or hold
// [RL9] External event pulses last at least one clock period
// [RL10] Other capture inputs stay usable while one input is the count clock
// [RL11] Pins combine by OR/AND into captures; match outputs broadcast
// [RL12] Count steps when prescale counter wraps; match when count equals value
module timer_capture_match_unit #(
  parameter int CAP_PINS = 8,
  parameter int MAT_PINS = 8
) (
  input  wire logic                        clk_in,
  input  wire logic                        rst_n_in,
  input  wire logic [tmr_pkg::ADDR_W-1:0]  awaddr_in,
  input  wire logic                        awvalid_in,
  output logic                             awready_out,
  input  wire logic [tmr_pkg::DATA_W-1:0]  wdata_in,
  input  wire logic [tmr_pkg::STRB_W-1:0]  wstrb_in,
  input  wire logic                        wvalid_in,
  output logic                             wready_out,
  output logic [1:0]                       bresp_out,
  output logic                             bvalid_out,
  input  wire logic                        bready_in,
  input  wire logic [tmr_pkg::ADDR_W-1:0]  araddr_in,
  input  wire logic                        arvalid_in,
  output logic                             arready_out,
  output logic [tmr_pkg::DATA_W-1:0]       rdata_out,
  output logic [1:0]                       rresp_out,
  output logic                             rvalid_out,
  input  wire logic                        rready_in,
  input  wire logic [CAP_PINS-1:0]         cap_pins_in,
  output logic [MAT_PINS-1:0]              match_pins_out,
  output logic                             irq_out
);
  localparam int CH = tmr_pkg::CHANS;

  logic [1:0]                rst_sync;
  logic                      rst_n;
  tmr_pkg::ctrl_t            ctrl, next_ctrl;
  tmr_pkg::word_t            tc, next_tc, pc, next_pc;
  tmr_pkg::word_t            prescale, next_prescale;
  tmr_pkg::word_t            match_val [CH];
  tmr_pkg::word_t            next_match_val [CH];
  tmr_pkg::word_t            cap_val [CH];
  tmr_pkg::word_t            next_cap_val [CH];
  tmr_pkg::mctl_vec_t        mctl, next_mctl;
  tmr_pkg::cctl_vec_t        cctl, next_cctl;
  tmr_pkg::act_vec_t         act, next_act;
  logic [CH-1:0]             ext, next_ext;
  logic [CH-1:0]             combine, next_combine;
  logic [tmr_pkg::IRQ_W-1:0] status, next_status, mask, next_mask;
  logic [CH*CAP_PINS-1:0]    cap_route, next_cap_route;
  logic [2*MAT_PINS-1:0]     pin_route, next_pin_route;
  logic [MAT_PINS-1:0]       next_match_pins;
  logic                      next_irq;
  logic [CH-1:0]             cap_rise, cap_fall, cap_evt, hit;
  logic                      tick, step;
  logic [tmr_pkg::IRQ_W-1:0] set_bits, clr_bits;
  tmr_pkg::word_t            wv;
  logic                      wr_fire, rd_fire;
  logic                      next_awready, next_bvalid, next_arready;
  logic                      next_rvalid;
  logic [1:0]                next_bresp, next_rresp;
  tmr_pkg::word_t            next_rdata;

  // Release of the asynchronous reset is made synchronous
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  function automatic tmr_pkg::addr_t word_addr(input tmr_pkg::addr_t base,
                                               input int i);
    word_addr = base + tmr_pkg::addr_t'(i) * tmr_pkg::WORD_STEP;
  endfunction

  function automatic logic mapped(input tmr_pkg::addr_t a);
    mapped = (a[1:0] == tmr_pkg::ALIGN_OK) && (a <= tmr_pkg::OFS_PIN_ROUTE);
  endfunction

  function automatic tmr_pkg::word_t merge(input tmr_pkg::word_t old,
                                           input tmr_pkg::word_t wd,
                                           input logic [3:0] strb);
    for (int b = 0; b < tmr_pkg::STRB_W; b++) begin
      merge[8*b +: 8] = strb[b] ? wd[8*b +: 8] : old[8*b +: 8];
    end
  endfunction

  function automatic tmr_pkg::word_t reg_word(input tmr_pkg::addr_t a);
    reg_word = tmr_pkg::ZERO_WORD;
    case (a)
      tmr_pkg::OFS_CTRL:      reg_word[tmr_pkg::CTRL_W-1:0] = ctrl;
      tmr_pkg::OFS_COUNT:     reg_word = tc;
      tmr_pkg::OFS_PRESCALE:  reg_word = prescale;
      tmr_pkg::OFS_PRECOUNT:  reg_word = pc;
      tmr_pkg::OFS_MATCH_CTL: reg_word[tmr_pkg::MCTL_W-1:0] = mctl;
      tmr_pkg::OFS_CAP_CTL:   reg_word[tmr_pkg::MCTL_W-1:0] = cctl;
      tmr_pkg::OFS_EXT_MATCH: reg_word[CH+tmr_pkg::ACT_W-1:0] = {act, ext};
      tmr_pkg::OFS_IRQ_STAT:  reg_word[tmr_pkg::IRQ_W-1:0] = status;
      tmr_pkg::OFS_IRQ_MASK:  reg_word[tmr_pkg::IRQ_W-1:0] = mask;
      tmr_pkg::OFS_COMBINE:   reg_word[CH-1:0] = combine;
      tmr_pkg::OFS_CAP_ROUTE: reg_word[CH*CAP_PINS-1:0] = cap_route;
      tmr_pkg::OFS_PIN_ROUTE: reg_word[2*MAT_PINS-1:0] = pin_route;
      default: ;
    endcase
    for (int i = 0; i < CH; i++) begin
      if (a == word_addr(tmr_pkg::OFS_MATCH0, i)) reg_word = match_val[i];
      if (a == word_addr(tmr_pkg::OFS_CAPTURE0, i)) reg_word = cap_val[i];
    end
  endfunction

  // Each channel may also act as a plain edge interrupt source
  for (genvar g = 0; g < CH; g++) begin : g_cap
    cap_input #(.PINS(CAP_PINS)) u_cap (
      .clk_in      (clk_in),
      .rst_n_in    (rst_n),
      .pins_in     (cap_pins_in),
      .route_in    (cap_route[g*CAP_PINS +: CAP_PINS]),
      .and_mode_in (combine[g]),
      .rise_out    (cap_rise[g]),
      .fall_out    (cap_fall[g])
    );
  end

  assign wr_fire = awready_out && awvalid_in && wvalid_in;
  assign rd_fire = arready_out && arvalid_in;

  always_comb begin
    next_ctrl = ctrl;
    next_tc = tc;
    next_pc = pc;
    next_prescale = prescale;
    next_match_val = match_val;
    next_cap_val = cap_val;
    next_mctl = mctl;
    next_cctl = cctl;
    next_act = act;
    next_ext = ext;
    next_combine = combine;
    next_mask = mask;
    next_cap_route = cap_route;
    next_pin_route = pin_route;
    wv = merge(reg_word(awaddr_in), wdata_in, wstrb_in);
    step = 1'b0;
    if (ctrl.mode == tmr_pkg::MODE_TIMER) begin
      tick = 1'b1; // RL1
    end else begin
      tick = (cap_rise[ctrl.cnt_sel] && ctrl.mode[0]) ||
             (cap_fall[ctrl.cnt_sel] && ctrl.mode[1]); // RL1
    end
    if (ctrl.en && !ctrl.rst && tick) begin
      if (pc == prescale) begin
        next_pc = tmr_pkg::ZERO_WORD; // RL12
        step = 1'b1;
      end else begin
        next_pc = pc + tmr_pkg::ONE_WORD; // RL2
      end
    end
    for (int i = 0; i < CH; i++) begin
      hit[i] = step && (tc == match_val[i]); // RL12
      cap_evt[i] = (cap_rise[i] && cctl[i].rise) ||
                   (cap_fall[i] && cctl[i].fall); // RL10
      if (cap_evt[i]) next_cap_val[i] = tc; // RL3
      set_bits[i] = hit[i] && mctl[i].irq; // RL5
      set_bits[tmr_pkg::CAP_LSB+i] = cap_evt[i] && cctl[i].irq; // RL4
      if (hit[i] && mctl[i].stop) next_ctrl.en = 1'b0; // RL6
      if (hit[i]) begin
        unique case (act[i])
          tmr_pkg::ACT_NONE:   next_ext[i] = ext[i]; // RL8
          tmr_pkg::ACT_LOW:    next_ext[i] = 1'b0; // RL8
          tmr_pkg::ACT_HIGH:   next_ext[i] = 1'b1; // RL8
          tmr_pkg::ACT_TOGGLE: next_ext[i] = !ext[i]; // RL8
        endcase
      end
    end
    if (step) begin
      next_tc = tc + tmr_pkg::ONE_WORD; // RL5
      for (int i = 0; i < CH; i++) begin
        if (hit[i] && mctl[i].rst) next_tc = tmr_pkg::ZERO_WORD; // RL7
      end
    end
    if (ctrl.rst) begin
      next_tc = tmr_pkg::ZERO_WORD;
      next_pc = tmr_pkg::ZERO_WORD;
    end
    // A software write lands after the hardware update, so it wins
    if (wr_fire) begin
      case (awaddr_in)
        tmr_pkg::OFS_CTRL:      next_ctrl = wv[tmr_pkg::CTRL_W-1:0];
        tmr_pkg::OFS_COUNT:     next_tc = wv;
        tmr_pkg::OFS_PRESCALE:  next_prescale = wv; // RL2
        tmr_pkg::OFS_PRECOUNT:  next_pc = wv;
        tmr_pkg::OFS_MATCH_CTL: next_mctl = wv[tmr_pkg::MCTL_W-1:0];
        tmr_pkg::OFS_CAP_CTL:   next_cctl = wv[tmr_pkg::MCTL_W-1:0];
        tmr_pkg::OFS_EXT_MATCH: {next_act, next_ext} =
                                  wv[CH+tmr_pkg::ACT_W-1:0];
        tmr_pkg::OFS_IRQ_MASK:  next_mask = wv[tmr_pkg::IRQ_W-1:0];
        tmr_pkg::OFS_COMBINE:   next_combine = wv[CH-1:0]; // RL11
        tmr_pkg::OFS_CAP_ROUTE: next_cap_route = wv[CH*CAP_PINS-1:0];
        tmr_pkg::OFS_PIN_ROUTE: next_pin_route = wv[2*MAT_PINS-1:0];
        default: ;
      endcase
      for (int i = 0; i < CH; i++) begin
        if (awaddr_in == word_addr(tmr_pkg::OFS_MATCH0, i)) begin
          next_match_val[i] = wv;
        end
      end
    end
    clr_bits = '0;
    if (rd_fire && araddr_in == tmr_pkg::OFS_IRQ_STAT) clr_bits = status;
    next_status = (status & ~clr_bits) | set_bits;
    next_irq = |(next_status & next_mask);
    for (int p = 0; p < MAT_PINS; p++) begin
      next_match_pins[p] = next_ext[pin_route[2*p +: 2]]; // RL11
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= '0;
      tc <= tmr_pkg::ZERO_WORD;
      pc <= tmr_pkg::ZERO_WORD;
      prescale <= tmr_pkg::ZERO_WORD;
      for (int i = 0; i < CH; i++) begin
        match_val[i] <= tmr_pkg::ZERO_WORD;
        cap_val[i] <= tmr_pkg::ZERO_WORD;
      end
      mctl <= '0;
      cctl <= '0;
      act <= '0;
      ext <= '0;
      combine <= '0;
      status <= '0;
      mask <= '0;
      cap_route <= '0;
      pin_route <= '0;
      match_pins_out <= '0;
      irq_out <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      tc <= next_tc;
      pc <= next_pc;
      prescale <= next_prescale;
      match_val <= next_match_val;
      cap_val <= next_cap_val;
      mctl <= next_mctl;
      cctl <= next_cctl;
      act <= next_act;
      ext <= next_ext;
      combine <= next_combine;
      status <= next_status;
      mask <= next_mask;
      cap_route <= next_cap_route;
      pin_route <= next_pin_route;
      match_pins_out <= next_match_pins;
      irq_out <= next_irq;
    end
  end

  // Both write channels are taken together, so no address is ever stored
  always_comb begin
    next_awready = awvalid_in && wvalid_in && !awready_out && !bvalid_out;
    next_bvalid = bvalid_out && !bready_in;
    next_bresp = bresp_out;
    if (wr_fire) begin
      next_bvalid = 1'b1;
      next_bresp = mapped(awaddr_in) ? tmr_pkg::RESP_OKAY
                                     : tmr_pkg::RESP_SLVERR;
    end
    next_arready = arvalid_in && !arready_out && !rvalid_out;
    next_rvalid = rvalid_out && !rready_in;
    next_rresp = rresp_out;
    next_rdata = rdata_out;
    if (rd_fire) begin
      next_rvalid = 1'b1;
      next_rdata = reg_word(araddr_in);
      next_rresp = mapped(araddr_in) ? tmr_pkg::RESP_OKAY
                                     : tmr_pkg::RESP_SLVERR;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      awready_out <= 1'b0;
      wready_out <= 1'b0;
      bvalid_out <= 1'b0;
      bresp_out <= tmr_pkg::RESP_OKAY;
      arready_out <= 1'b0;
      rvalid_out <= 1'b0;
      rresp_out <= tmr_pkg::RESP_OKAY;
      rdata_out <= tmr_pkg::ZERO_WORD;
    end else begin
      awready_out <= next_awready;
      wready_out <= next_awready;
      bvalid_out <= next_bvalid;
      bresp_out <= next_bresp;
      arready_out <= next_arready;
      rvalid_out <= next_rvalid;
      rresp_out <= next_rresp;
      rdata_out <= next_rdata;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n);

  sequence s_plain_step;
    step && !ctrl.rst && !(|(hit & {mctl[3].rst, mctl[2].rst,
                                     mctl[1].rst, mctl[0].rst})) && !wr_fire;
  endsequence
  sequence s_reset_hit;
    step && hit[1] && mctl[1].rst && !ctrl.rst && !wr_fire;
  endsequence

  a_count_step: assert property ( // RL12
    s_plain_step |=> tc == $past(tc) + tmr_pkg::ONE_WORD)
    else $error("count did not step by one on prescale wrap");
  a_prescale_hold: assert property ( // RL2
    ctrl.en && !ctrl.rst && tick && pc != prescale && !wr_fire
    |=> tc == $past(tc) && pc == $past(pc) + tmr_pkg::ONE_WORD)
    else $error("prescale counter did not advance alone");
  a_timer_tick: assert property ( // RL1
    ctrl.en && !ctrl.rst && ctrl.mode == tmr_pkg::MODE_TIMER && !wr_fire
    |=> pc != $past(pc) || tc != $past(tc))
    else $error("timer mode failed to count a clock");
  a_match_reset: assert property ( // RL7
    s_reset_hit |=> tc == tmr_pkg::ZERO_WORD)
    else $error("reset-on-match did not clear the count");
  a_match_stop: assert property ( // RL6
    hit[0] && mctl[0].stop && !wr_fire |=> !ctrl.en ##1
    ($past(wr_fire) || tc == $past(tc)))
    else $error("stop-on-match did not halt the counter");
  a_capture_load: assert property ( // RL3
    cap_evt[2] |=> cap_val[2] == $past(tc))
    else $error("capture did not load the count");
  a_capture_irq: assert property ( // RL4
    cap_evt[3] && !cctl[3].irq && !status[tmr_pkg::CAP_LSB+3]
    |=> !status[tmr_pkg::CAP_LSB+3])
    else $error("disabled capture set its interrupt flag");
  a_ext_toggle: assert property ( // RL8
    hit[1] && act[1] == tmr_pkg::ACT_TOGGLE && !wr_fire
    |=> ext[1] != $past(ext[1]))
    else $error("toggle-on-match left the output unchanged");
  a_irq_level: assert property (irq_out == |(status & mask))
    else $error("interrupt output disagrees with masked status");
  a_write_resp: assert property (wr_fire |=> bvalid_out)
    else $error("write response did not follow the handshake");
endmodule // timer_capture_match_unit

// >>> core/tmr_pkg.sv
// Register map, field layouts and types for the timer capture match unit
package tmr_pkg;
  localparam int ADDR_W  = 8;
  localparam int DATA_W  = 32;
  localparam int STRB_W  = DATA_W / 8;
  localparam int CHANS   = 4;
  localparam int CTRL_W  = 6;
  localparam int MCTL_W  = 3 * CHANS;
  localparam int ACT_W   = 2 * CHANS;
  localparam int IRQ_W   = 2 * CHANS;
  localparam int CAP_LSB = CHANS;

  typedef logic [ADDR_W-1:0] addr_t;
  typedef logic [DATA_W-1:0] word_t;

  localparam addr_t OFS_CTRL      = 8'h00;
  localparam addr_t OFS_COUNT     = 8'h04;
  localparam addr_t OFS_PRESCALE  = 8'h08;
  localparam addr_t OFS_PRECOUNT  = 8'h0c;
  localparam addr_t OFS_MATCH_CTL = 8'h10;
  localparam addr_t OFS_MATCH0    = 8'h14;
  localparam addr_t OFS_CAP_CTL   = 8'h24;
  localparam addr_t OFS_CAPTURE0  = 8'h28;
  localparam addr_t OFS_EXT_MATCH = 8'h38;
  localparam addr_t OFS_IRQ_STAT  = 8'h3c;
  localparam addr_t OFS_IRQ_MASK  = 8'h40;
  localparam addr_t OFS_COMBINE   = 8'h44;
  localparam addr_t OFS_CAP_ROUTE = 8'h48;
  localparam addr_t OFS_PIN_ROUTE = 8'h4c;
  localparam addr_t WORD_STEP     = 8'h04;
  localparam logic [1:0] ALIGN_OK = 2'h0;

  localparam word_t ZERO_WORD = 32'h0;
  localparam word_t ONE_WORD  = 32'h1;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    MODE_TIMER = 2'b00,
    MODE_RISE  = 2'b01,
    MODE_FALL  = 2'b10,
    MODE_BOTH  = 2'b11
  } count_mode_t;

  typedef enum logic [1:0] {
    ACT_NONE   = 2'b00,
    ACT_LOW    = 2'b01,
    ACT_HIGH   = 2'b10,
    ACT_TOGGLE = 2'b11
  } ext_action_t;

  typedef struct packed {
    logic [1:0]  cnt_sel;
    count_mode_t mode;
    logic        rst;
    logic        en;
  } ctrl_t;

  typedef struct packed {
    logic stop;
    logic rst;
    logic irq;
  } match_ctl_t;

  typedef struct packed {
    logic irq;
    logic fall;
    logic rise;
  } cap_ctl_t;

  typedef match_ctl_t  [CHANS-1:0] mctl_vec_t;
  typedef cap_ctl_t    [CHANS-1:0] cctl_vec_t;
  typedef ext_action_t [CHANS-1:0] act_vec_t;
endpackage
